// [src/cid_pkg.sv]
// constants and types shared by the instruction datapath
package cid_pkg;

  // operations the datapath carries out
  typedef enum logic [5:0] {
    add_op, add_carry_op, sub_op, sub_carry_op, reverse_sub_op,
    compare_op, compare_neg_op,
    and_op, or_op, or_not_op, xor_op, bit_clear_op, move_op,
    move_not_op, test_op, test_equal_op,
    shift_left_op, shift_right_op, shift_arith_op, rotate_op,
    rotate_extend_op,
    multiply_accumulate_op, multiply_subtract_op,
    signed_long_multiply_op, signed_long_mac_op,
    signed_divide_op, unsigned_divide_op,
    signed_saturate_op, unsigned_saturate_op,
    word_byte_reverse_op, halfword_byte_swap_op, low_half_swap_sext_op,
    signed_field_extract_op, unsigned_field_extract_op, field_clear_op,
    block_load_ascending_op, block_load_descending_op,
    block_store_ascending_op, block_store_descending_op,
    branch_if_zero_op, branch_if_nonzero_op,
    irq_mask_set_op, irq_mask_clear_op, write_special_reg_op, nop_op
  } cid_op_type;

  // condition codes
  localparam logic [3:0] COND_EQ = 4'h0;
  localparam logic [3:0] COND_NE = 4'h1;
  localparam logic [3:0] COND_CS = 4'h2;
  localparam logic [3:0] COND_CC = 4'h3;
  localparam logic [3:0] COND_MI = 4'h4;
  localparam logic [3:0] COND_PL = 4'h5;
  localparam logic [3:0] COND_VS = 4'h6;
  localparam logic [3:0] COND_VC = 4'h7;
  localparam logic [3:0] COND_HI = 4'h8;
  localparam logic [3:0] COND_LS = 4'h9;
  localparam logic [3:0] COND_GE = 4'ha;
  localparam logic [3:0] COND_LT = 4'hb;
  localparam logic [3:0] COND_GT = 4'hc;
  localparam logic [3:0] COND_LE = 4'hd;

  // flag positions inside the flag word
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 0;

  // special register layout written by write_special_reg_op
  localparam int SPECIAL_NZCV_LSB = 28;
  localparam int SPECIAL_Q_BIT    = 27;

  // reset values and block transfer word size
  localparam logic [3:0] FLAGS_RESET     = 4'h0;
  localparam logic       IRQ_MASK_RESET  = 1'b0;
  localparam int         XFER_WORD_SHIFT = 2;

endpackage

// [src/cid_datapath.sv]
// execution datapath with condition flags for the instruction set
`timescale 1ns/1ps

// What this block does
// - second operand is either a register or an immediate constant
// - condition code checked against flags decides whether op takes effect, except compare-and-branch, which ignores it
// - flag-setting add, sub, carry forms, reverse sub, compares set NZCV
// - flag-setting logical, move, test ops set NZ, keep C and V; shift and rotate ops set NZC, keep V
// - saturate clamps to programmed range, optional pre-shift, sets sticky Q
// - multiply-accumulate keeps low 32 bits of a*b+c
// - multiply-subtract gives c minus a*b as 32 bits
// - signed long multiply writes full 64-bit product to a pair
// - signed long mac adds signed product to 64-bit pair
// - reverse all four bytes, or swap bytes in each halfword
// - swap bytes of low halfword and sign extend to 32 bits
// - field extract right-aligns field, sign or zero extends
// - field clear zeroes a field, other bits unchanged
// - block load ascends after or descends before, optional write-back
// - block store ascends after or descends before, optional write-back
// - compare-and-branch on zero or non-zero, no flag change
// - interrupt mask set or cleared; special write loads NZCV
module cid_datapath
  import cid_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // operation request
  input  wire logic        op_valid_i,
  input  wire cid_op_type  op_i,
  input  wire logic [3:0]  cond_i,
  input  wire logic        set_flags_i,
  input  wire logic        use_imm_i,
  input  wire logic [31:0] imm_i,
  input  wire logic [31:0] opa_i,
  input  wire logic [31:0] opb_i,
  input  wire logic [31:0] opc_i,
  input  wire logic [31:0] acc_hi_i,
  // saturate, field and block controls
  input  wire logic [5:0]  sat_bits_i,
  input  wire logic [4:0]  sat_shift_i,
  input  wire logic        sat_asr_i,
  input  wire logic [4:0]  field_lsb_i,
  input  wire logic [5:0]  field_width_i,
  input  wire logic [15:0] reglist_i,
  input  wire logic        base_wb_i,
  // results
  output logic             res_valid_o,
  output logic             executed_o,
  output logic [31:0]      result_o,
  output logic [31:0]      result_hi_o,
  output logic             wr_rd_o,
  output logic             wr_pair_o,
  output logic             branch_o,
  // block transfer
  output logic             xfer_o,
  output logic             xfer_load_o,
  output logic [31:0]      xfer_addr_o,
  output logic [4:0]       xfer_count_o,
  output logic [31:0]      base_new_o,
  output logic             base_wb_o,
  // processor state
  output logic [3:0]       flags_o,
  output logic             sat_q_o,
  output logic             irq_mask_o
);

  // counts the registers named in a block transfer list
  function automatic logic [4:0] count_regs(input logic [15:0] list);
    logic [4:0] n;
    n = 5'h0;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, list[i]};
    end
    return n;
  endfunction

  logic        cond_pass;
  logic [31:0] alu_res;
  logic [31:0] alu_hi;
  logic        alu_c;
  logic        alu_v;
  logic [3:0]  next_flags;
  logic        next_q;
  logic        next_mask;

  wire fn = flags_o[FLAG_N];
  wire fz = flags_o[FLAG_Z];
  wire fc = flags_o[FLAG_C];
  wire fv = flags_o[FLAG_V];

  // operand select and operation groups
  wire [31:0] flexible_second_operand = use_imm_i ? imm_i : opb_i;
  wire is_arith = op_i inside {add_op, add_carry_op, sub_op,
                               sub_carry_op, reverse_sub_op};
  wire is_cmp   = op_i inside {compare_op, compare_neg_op};
  wire is_test  = op_i inside {test_op, test_equal_op};
  wire is_logic = op_i inside {and_op, or_op, or_not_op, xor_op,
                               bit_clear_op, move_op, move_not_op,
                               shift_left_op, shift_right_op,
                               shift_arith_op, rotate_op,
                               rotate_extend_op};
  wire is_sat   = op_i inside {signed_saturate_op, unsigned_saturate_op};
  wire is_cb    = op_i inside {branch_if_zero_op, branch_if_nonzero_op};
  wire is_xfer  = op_i inside {block_load_ascending_op,
                               block_load_descending_op,
                               block_store_ascending_op,
                               block_store_descending_op};
  wire is_desc  = op_i inside {block_load_descending_op,
                               block_store_descending_op};
  wire is_pair  = op_i inside {signed_long_multiply_op,
                               signed_long_mac_op};
  wire no_wr    = is_cmp | is_test | is_xfer | is_cb |
                  op_i inside {irq_mask_set_op, irq_mask_clear_op,
                               write_special_reg_op, nop_op};
  wire exec     = cond_pass | is_cb;
  wire take     = op_valid_i & exec;

  // flag update enables
  wire upd_nzc = ((is_arith | is_logic) & set_flags_i)
                 | is_cmp | is_test;
  wire upd_v   = (is_arith & set_flags_i) | is_cmp;

  // condition code evaluation
  always_comb begin
    case (cond_i)
      COND_EQ: cond_pass = fz;
      COND_NE: cond_pass = !fz;
      COND_CS: cond_pass = fc;
      COND_CC: cond_pass = !fc;
      COND_MI: cond_pass = fn;
      COND_PL: cond_pass = !fn;
      COND_VS: cond_pass = fv;
      COND_VC: cond_pass = !fv;
      COND_HI: cond_pass = fc & !fz;
      COND_LS: cond_pass = !fc | fz;
      COND_GE: cond_pass = fn == fv;
      COND_LT: cond_pass = fn != fv;
      COND_GT: cond_pass = !fz & (fn == fv);
      COND_LE: cond_pass = fz | (fn != fv);
      default: cond_pass = 1'b1;
    endcase
  end

  // adder shared by add, subtract, reverse subtract and compares
  wire is_subx  = op_i inside {sub_op, sub_carry_op, compare_op};
  wire is_rsb   = op_i == reverse_sub_op;
  wire [31:0] add_x = is_rsb ? flexible_second_operand : opa_i;
  wire [31:0] add_y = is_rsb  ? ~opa_i :
                      is_subx ? ~flexible_second_operand :
                      flexible_second_operand;
  wire add_cin = (op_i inside {add_carry_op, sub_carry_op}) ? fc :
                 (is_subx | is_rsb);
  wire [32:0] sum33 = {1'b0, add_x} + {1'b0, add_y} + {32'h0, add_cin};
  wire add_v = (add_x[31] == add_y[31]) & (sum33[31] != add_x[31]);

  // shifter, amount from the low byte of the second operand
  wire [7:0]  sh      = flexible_second_operand[7:0];
  wire        sh_zero = sh == 8'h0;
  wire [63:0] lsl_w   = {32'h0, opa_i} << sh;
  wire [63:0] lsr_w   = {opa_i, 32'h0} >> sh;
  wire [63:0] asr_w   = $signed({opa_i, 32'h0}) >>> sh;
  wire [4:0]  rot     = sh[4:0];
  wire [31:0] ror_r   = (opa_i >> rot) | (opa_i << (6'd32 - {1'b0, rot}));

  // multipliers and dividers
  wire [31:0] mul_lo = 32'(opa_i * opb_i);
  wire signed [63:0] prod_s = $signed(opa_i) * $signed(opb_i);
  wire [63:0] signed_long_mac_op_r = 64'(prod_s + $signed({acc_hi_i, opc_i}));
  wire div_ovf = (opa_i == 32'h8000_0000) & (opb_i == 32'hffff_ffff);
  wire [31:0] unsigned_divide_op_r = (opb_i == 32'h0) ? 32'h0 : opa_i / opb_i;
  wire [31:0] signed_divide_op_r = (opb_i == 32'h0) ? 32'h0 :
                       div_ovf ? 32'h8000_0000 :
                       32'($signed(opa_i) / $signed(opb_i));

  // saturation with optional pre-shift
  wire [31:0] sat_in = sat_asr_i ? 32'($signed(opa_i) >>> sat_shift_i)
                                 : opa_i << sat_shift_i;
  wire signed [63:0] sat_w  = 64'($signed(sat_in));
  wire [5:0]         sat_nm = (op_i == signed_saturate_op) ?
                              sat_bits_i - 6'h1 : sat_bits_i;
  wire signed [63:0] sat_hi = (64'sd1 <<< sat_nm) - 64'sd1;
  wire signed [63:0] sat_lo = (op_i == signed_saturate_op) ?
                              -sat_hi - 64'sd1 : 64'sd0;
  wire sat_over  = sat_w > sat_hi;
  wire sat_under = sat_w < sat_lo;
  wire sat_hit   = is_sat & (sat_over | sat_under);
  wire [31:0] sat_r = sat_over  ? sat_hi[31:0] :
                      sat_under ? sat_lo[31:0] : sat_in;

  // bit-field extract and clear
  wire [31:0] fld_low  = 32'((64'h1 << field_width_i) - 64'h1);
  wire [31:0] fld_mask = fld_low << field_lsb_i;
  wire [5:0]  signed_field_extract_op_up  = 6'd32 - {1'b0, field_lsb_i} - field_width_i;
  wire [5:0]  signed_field_extract_op_dn  = 6'd32 - field_width_i;
  wire [31:0] unsigned_field_extract_op_r   = (opa_i >> field_lsb_i) & fld_low;
  wire [31:0] signed_field_extract_op_r   = 32'($signed(opa_i << signed_field_extract_op_up) >>> signed_field_extract_op_dn);

  // block transfer addresses, one word per listed register
  wire [4:0]  xfer_n     = count_regs(reglist_i);
  wire [31:0] xfer_bytes = {25'h0, xfer_n, 2'b0} << (XFER_WORD_SHIFT - 2);
  wire [31:0] base_up    = opa_i + xfer_bytes;
  wire [31:0] base_down  = opa_i - xfer_bytes;

  // result selection
  always_comb begin
    alu_res = sum33[31:0];
    alu_hi  = 32'h0;
    alu_c   = fc;
    alu_v   = fv;
    case (op_i)
      add_op, add_carry_op, sub_op, sub_carry_op, reverse_sub_op,
      compare_op, compare_neg_op: begin
        alu_c = sum33[32];
        alu_v = add_v;
      end
      and_op, test_op: alu_res = opa_i & flexible_second_operand;
      or_op:           alu_res = opa_i | flexible_second_operand;
      or_not_op:       alu_res = opa_i | ~flexible_second_operand;
      xor_op, test_equal_op: alu_res = opa_i ^ flexible_second_operand;
      bit_clear_op:    alu_res = opa_i & ~flexible_second_operand;
      move_op:         alu_res = flexible_second_operand;
      move_not_op:     alu_res = ~flexible_second_operand;
      shift_left_op: begin
        alu_res = lsl_w[31:0];
        alu_c   = sh_zero ? fc : lsl_w[32];
      end
      shift_right_op: begin
        alu_res = lsr_w[63:32];
        alu_c   = sh_zero ? fc : lsr_w[31];
      end
      shift_arith_op: begin
        alu_res = asr_w[63:32];
        alu_c   = sh_zero ? fc : asr_w[31];
      end
      rotate_op: begin
        alu_res = ror_r;
        alu_c   = sh_zero ? fc : ror_r[31];
      end
      rotate_extend_op: begin
        alu_res = {fc, opa_i[31:1]};
        alu_c   = opa_i[0];
      end
      multiply_accumulate_op: alu_res = mul_lo + opc_i;
      multiply_subtract_op:   alu_res = opc_i - mul_lo;
      signed_long_multiply_op: begin
        alu_res = prod_s[31:0];
        alu_hi  = prod_s[63:32];
      end
      signed_long_mac_op: begin
        alu_res = signed_long_mac_op_r[31:0];
        alu_hi  = signed_long_mac_op_r[63:32];
      end
      signed_divide_op:   alu_res = signed_divide_op_r;
      unsigned_divide_op: alu_res = unsigned_divide_op_r;
      signed_saturate_op, unsigned_saturate_op: alu_res = sat_r;
      word_byte_reverse_op:
        alu_res = {opa_i[7:0], opa_i[15:8], opa_i[23:16], opa_i[31:24]};
      halfword_byte_swap_op:
        alu_res = {opa_i[23:16], opa_i[31:24], opa_i[7:0], opa_i[15:8]};
      low_half_swap_sext_op:
        alu_res = {{16{opa_i[7]}}, opa_i[7:0], opa_i[15:8]};
      signed_field_extract_op:   alu_res = signed_field_extract_op_r;
      unsigned_field_extract_op: alu_res = unsigned_field_extract_op_r;
      field_clear_op:            alu_res = opc_i & ~fld_mask;
      default:                   alu_res = 32'h0;
    endcase
  end

  // next processor state: flags, sticky saturation, interrupt mask
  always_comb begin
    next_flags = flags_o;
    next_q     = sat_q_o | (take & sat_hit);
    next_mask  = irq_mask_o;
    if (take && upd_nzc) begin
      next_flags[FLAG_N] = alu_res[31];
      next_flags[FLAG_Z] = alu_res == 32'h0;
      next_flags[FLAG_C] = alu_c;
    end
    if (take && upd_v) begin
      next_flags[FLAG_V] = alu_v;
    end
    if (take && op_i == write_special_reg_op) begin
      next_flags = opa_i[SPECIAL_NZCV_LSB +: 4];
      next_q     = opa_i[SPECIAL_Q_BIT];
    end
    if (take && op_i == irq_mask_set_op) begin
      next_mask = 1'b1;
    end
    if (take && op_i == irq_mask_clear_op) begin
      next_mask = 1'b0;
    end
  end

  // processor state registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_o    <= FLAGS_RESET;
      sat_q_o    <= 1'b0;
      irq_mask_o <= IRQ_MASK_RESET;
    end else begin
      flags_o    <= next_flags;
      sat_q_o    <= next_q;
      irq_mask_o <= next_mask;
    end
  end

  // branch decision, never touching the flags
  wire cb_hit = (op_i == branch_if_zero_op) ? (opa_i == 32'h0)
                                            : (opa_i != 32'h0);

  // result and handshake registers, one-cycle answer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_valid_o <= 1'b0;
      executed_o  <= 1'b0;
      wr_rd_o     <= 1'b0;
      wr_pair_o   <= 1'b0;
      branch_o    <= 1'b0;
      xfer_o      <= 1'b0;
      base_wb_o   <= 1'b0;
      result_o    <= 32'h0;
      result_hi_o <= 32'h0;
    end else begin
      res_valid_o <= op_valid_i;
      executed_o  <= take;
      wr_rd_o     <= take & !no_wr & !is_pair;
      wr_pair_o   <= take & is_pair;
      branch_o    <= op_valid_i & is_cb & cb_hit;
      xfer_o      <= take & is_xfer;
      base_wb_o   <= take & is_xfer & base_wb_i;
      if (op_valid_i) begin
        result_o    <= alu_res;
        result_hi_o <= alu_hi;
      end
    end
  end

  // block transfer address registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xfer_load_o  <= 1'b0;
      xfer_addr_o  <= 32'h0;
      xfer_count_o <= 5'h0;
      base_new_o   <= 32'h0;
    end else if (op_valid_i && is_xfer) begin
      xfer_load_o  <= op_i inside {block_load_ascending_op,
                                   block_load_descending_op};
      xfer_addr_o  <= is_desc ? base_down : opa_i;
      base_new_o   <= is_desc ? base_down : base_up;
      xfer_count_o <= xfer_n;
    end
  end

  // checks on the datapath behaviour
  default clocking dflt_clk @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_cond_skip: assert property (
    op_valid_i && !exec |=> !executed_o && !wr_rd_o &&
      flags_o == $past(flags_o))
    else $error("failed condition still took effect");

  a_compare_flags: assert property (
    op_valid_i && exec && op_i == compare_op |=>
      flags_o[FLAG_Z] == ($past(opa_i) == $past(flexible_second_operand))
      && flags_o[FLAG_C] ==
         ($past(opa_i) >= $past(flexible_second_operand)))
    else $error("compare flags wrong");

  a_logic_keep_v: assert property (
    op_valid_i && exec && is_logic && set_flags_i |=>
      $stable(flags_o[FLAG_V]) &&
      flags_o[FLAG_Z] == (result_o == 32'h0))
    else $error("logical op flags wrong");

  a_sat_sticky: assert property (
    $fell(sat_q_o) |-> $past(op_valid_i && op_i == write_special_reg_op))
    else $error("saturation flag cleared on its own");

  a_mac_low: assert property (
    op_valid_i && exec && op_i == multiply_accumulate_op |=>
      result_o == 32'($past(opa_i) * $past(opb_i) + $past(opc_i)))
    else $error("multiply-accumulate result wrong");

  a_long_mul: assert property (
    op_valid_i && exec && op_i == signed_long_multiply_op |=>
      wr_pair_o && $signed({result_hi_o, result_o}) ==
      $signed($past(opa_i)) * $signed($past(opb_i)))
    else $error("long multiply result wrong");

  a_rev_word: assert property (
    op_valid_i && op_i == word_byte_reverse_op |=>
      result_o[7:0] == $past(opa_i[31:24]) &&
      result_o[31:24] == $past(opa_i[7:0]))
    else $error("byte reverse wrong");

  a_field_clear: assert property (
    op_valid_i && op_i == field_clear_op |=>
      (result_o & ~$past(fld_mask)) == ($past(opc_i) & ~$past(fld_mask))
      && (result_o & $past(fld_mask)) == 32'h0)
    else $error("field clear touched other bits");

  a_cb_no_flags: assert property (
    op_valid_i && is_cb |=> $stable(flags_o) &&
      branch_o == ($past(op_i == branch_if_zero_op) ==
                   ($past(opa_i) == 32'h0)))
    else $error("compare-and-branch wrong");

  a_irq_mask: assert property (
    op_valid_i && exec && op_i == irq_mask_set_op |=> irq_mask_o ##1
      (irq_mask_o || $past(op_valid_i && op_i == irq_mask_clear_op)))
    else $error("interrupt mask not set");

  a_unsigned_divide_op_q: assert property (
    op_valid_i && exec && op_i == unsigned_divide_op && opb_i != 0 |=>
      result_o == $past(opa_i) / $past(opb_i) && $stable(flags_o))
    else $error("unsigned divide wrong");

  c_cond_fail: cover property (op_valid_i && !exec);
  c_sat_clamp: cover property (op_valid_i && exec && sat_hit);
  c_branch:    cover property (branch_o);
  c_block_dsc: cover property (op_valid_i && exec && is_desc);

endmodule

// [verif/tb_top.sv]
// self-checking testbench for the instruction datapath
`timescale 1ns/1ps
module tb_top
  import cid_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        op_valid = 1'b0;
  cid_op_type  op = nop_op;
  logic [3:0]  cond = 4'he;
  logic        set_flags = 1'b0;
  logic        use_imm = 1'b0;
  logic [31:0] imm = 32'h0;
  logic [31:0] opa = 32'h0;
  logic [31:0] opb = 32'h0;
  logic [31:0] opc = 32'h0;
  logic [31:0] acc_hi = 32'h0;
  logic [5:0]  sat_bits = 6'h08;
  logic [4:0]  sat_shift = 5'h00;
  logic        sat_asr = 1'b0;
  logic [4:0]  field_lsb = 5'h04;
  logic [5:0]  field_width = 6'h08;
  logic [15:0] reglist = 16'h0;
  logic        base_wb = 1'b0;
  logic        res_valid, executed, wr_rd, wr_pair, branch;
  logic        xfer, xfer_load, base_wb_out, sat_q, irq_mask;
  logic [31:0] result, result_hi, xfer_addr, base_new;
  logic [4:0]  xfer_count;
  logic [3:0]  flags;
  int          mismatches = 0;
  int          checks_done = 0;

  // 125 MHz clock
  always #4 clk = ~clk;

  cid_datapath dut_u (
    .clk_i(clk), .nrst_i(nrst), .op_valid_i(op_valid), .op_i(op),
    .cond_i(cond), .set_flags_i(set_flags), .use_imm_i(use_imm),
    .imm_i(imm), .opa_i(opa), .opb_i(opb), .opc_i(opc),
    .acc_hi_i(acc_hi), .sat_bits_i(sat_bits), .sat_shift_i(sat_shift),
    .sat_asr_i(sat_asr), .field_lsb_i(field_lsb),
    .field_width_i(field_width), .reglist_i(reglist),
    .base_wb_i(base_wb), .res_valid_o(res_valid), .executed_o(executed),
    .result_o(result), .result_hi_o(result_hi), .wr_rd_o(wr_rd),
    .wr_pair_o(wr_pair), .branch_o(branch), .xfer_o(xfer),
    .xfer_load_o(xfer_load), .xfer_addr_o(xfer_addr),
    .xfer_count_o(xfer_count), .base_new_o(base_new),
    .base_wb_o(base_wb_out), .flags_o(flags), .sat_q_o(sat_q),
    .irq_mask_o(irq_mask)
  );

  // compare one value and count it
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one request, raised an idle cycle after the last one so the strobe
  // never changes twice in a step; answer sampled just after the edge
  task automatic issue(input cid_op_type o, input logic [3:0] cd,
                       input logic sf, input logic [31:0] a,
                       input logic [31:0] b, input logic [31:0] c);
    @(posedge clk);
    #1;
    op_valid = 1'b1;
    op = o;
    cond = cd;
    set_flags = sf;
    opa = a;
    opb = b;
    opc = c;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
  endtask

  // print counts and verdict, then stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // arithmetic forms with register or constant operand
  task automatic t_arith();
    use_imm = 1'b1;
    imm = 32'h1;
    issue(add_op, 4'he, 1'b1, 32'hffffffff, 32'h5, 32'h0);
    chk({res_valid, wr_rd, result}, {2'b11, 32'h0});
    chk(flags, 4'h6);
    use_imm = 1'b0;
    issue(sub_op, 4'he, 1'b1, 32'h1, 32'h2, 32'h0);
    chk({result, flags}, {32'hffffffff, 4'h8});
    issue(compare_op, 4'he, 1'b1, 32'h5, 32'h5, 32'h0);
    chk(flags, 4'h6);
    issue(add_op, 4'he, 1'b1, 32'h7fffffff, 32'h1, 32'h0);
    chk({result, flags}, {32'h80000000, 4'h9});
  endtask

  // condition code failing and passing against current flags
  task automatic t_cond();
    issue(add_op, COND_VC, 1'b1, 32'h1, 32'h1, 32'h0);
    chk({res_valid, executed, wr_rd, flags}, {3'b100, 4'h9});
    issue(add_op, COND_GE, 1'b0, 32'h1, 32'h1, 32'h0);
    chk({executed, wr_rd, result}, {2'b11, 32'h2});
  endtask

  // logical and shift forms keep overflow; plain forms keep all flags
  task automatic t_logic();
    issue(and_op, 4'he, 1'b1, 32'hf0, 32'h0f, 32'h0);
    chk({result, flags}, {32'h0, 4'h5});
    issue(xor_op, 4'he, 1'b0, 32'hf0, 32'h0f, 32'h0);
    chk({result, flags}, {32'hff, 4'h5});
    issue(shift_left_op, 4'he, 1'b1, 32'h80000001, 32'h1, 32'h0);
    chk({result, flags}, {32'h2, 4'h3});
    issue(add_op, 4'he, 1'b0, 32'hffffffff, 32'h1, 32'h0);
    chk({result, flags}, {32'h0, 4'h3});
  endtask

  // multiply family, flags untouched by multiply-accumulate even with flag form asked
  task automatic t_mul();
    issue(multiply_accumulate_op, 4'he, 1'b1, 32'h10000, 32'h10001, 32'h5);
    chk({result, flags}, {32'h10005, 4'h3});
    issue(multiply_subtract_op, 4'he, 1'b0, 32'h3, 32'h4, 32'ha);
    chk(result, 32'hfffffffe);
    issue(signed_long_multiply_op, 4'he, 1'b0, 32'hfffffffe, 32'h3, 32'h0);
    chk({result_hi, result}, 64'hfffffffffffffffa);
    chk(wr_pair, 1'b1);
    acc_hi = 32'h1;
    issue(signed_long_mac_op, 4'he, 1'b0, 32'h2, 32'h3, 32'hffffffff);
    chk({result_hi, result}, 64'h0000000200000005);
  endtask

  // byte reversal, saturation and field operations
  task automatic t_bits();
    issue(word_byte_reverse_op, 4'he, 1'b0, 32'h12345680, 32'h0, 32'h0);
    chk(result, 32'h80563412);
    issue(halfword_byte_swap_op, 4'he, 1'b0, 32'h12345680, 32'h0, 32'h0);
    chk(result, 32'h34128056);
    issue(low_half_swap_sext_op, 4'he, 1'b0, 32'h12345680, 32'h0, 32'h0);
    chk(result, 32'hffff8056);
    issue(signed_field_extract_op, 4'he, 1'b0, 32'hf80, 32'h0, 32'h0);
    chk(result, 32'hfffffff8);
    issue(unsigned_field_extract_op, 4'he, 1'b0, 32'hf80, 32'h0, 32'h0);
    chk(result, 32'hf8);
    issue(field_clear_op, 4'he, 1'b0, 32'hffffffff, 32'h0, 32'hffffffff);
    chk({result, flags}, {32'hfffff00f, 4'h3});
    field_lsb = 5'h00;
    field_width = 6'h20;
    issue(unsigned_field_extract_op, 4'he, 1'b0, 32'h89abcdef, 32'h0, 32'h0);
    chk(result, 32'h89abcdef);
    sat_shift = 5'h02;
    issue(signed_saturate_op, 4'he, 1'b0, 32'h10, 32'h0, 32'h0);
    chk({result, sat_q}, {32'h40, 1'b0});
    sat_shift = 5'h00;
    issue(signed_saturate_op, 4'he, 1'b0, 32'h1000, 32'h0, 32'h0);
    chk({result, sat_q}, {32'h7f, 1'b1});
    issue(unsigned_saturate_op, 4'he, 1'b0, 32'hffffff00, 32'h0, 32'h0);
    chk({result, sat_q}, {32'h0, 1'b1});
  endtask

  // one block transfer and its address outputs
  task automatic blk(input cid_op_type o, input logic [31:0] base,
                     input logic [15:0] lst, input logic wb,
                     input logic [31:0] ea, input logic [4:0] ec,
                     input logic [31:0] eb, input logic ld);
    reglist = lst;
    base_wb = wb;
    issue(o, 4'he, 1'b0, base, 32'h0, 32'h0);
    chk({xfer, xfer_load, base_wb_out, xfer_count, xfer_addr},
        {1'b1, ld, wb, ec, ea});
    if (wb) begin
      chk(base_new, eb);
    end
  endtask

  // branches, interrupt mask, special write and divides
  task automatic t_ctrl();
    issue(branch_if_zero_op, 4'he, 1'b1, 32'h0, 32'h0, 32'h0);
    chk({branch, flags}, {1'b1, 4'h3});
    issue(branch_if_nonzero_op, 4'he, 1'b1, 32'h0, 32'h0, 32'h0);
    chk({branch, flags}, {1'b0, 4'h3});
    issue(branch_if_nonzero_op, COND_EQ, 1'b1, 32'h5, 32'h0, 32'h0);
    chk({branch, flags}, {1'b1, 4'h3});
    issue(irq_mask_set_op, 4'he, 1'b0, 32'h0, 32'h0, 32'h0);
    chk(irq_mask, 1'b1);
    issue(write_special_reg_op, 4'he, 1'b0, 32'ha0000000, 32'h0, 32'h0);
    chk({flags, sat_q}, {4'ha, 1'b0});
    issue(irq_mask_clear_op, COND_EQ, 1'b0, 32'h0, 32'h0, 32'h0);
    chk(irq_mask, 1'b1);
    issue(irq_mask_clear_op, 4'he, 1'b0, 32'h0, 32'h0, 32'h0);
    chk(irq_mask, 1'b0);
    issue(signed_divide_op, 4'he, 1'b1, 32'hfffffff9, 32'h2, 32'h0);
    chk({result, flags}, {32'hfffffffd, 4'ha});
    issue(unsigned_divide_op, 4'he, 1'b1, 32'hfffffff9, 32'h2, 32'h0);
    chk({result, flags}, {32'h7ffffffc, 4'ha});
  endtask

  // remaining arithmetic, logical and shift forms, shifted saturation
  task automatic t_forms();
    issue(add_carry_op, 4'he, 1'b1, 32'h1, 32'h1, 32'h0);
    chk({result, flags}, {32'h3, 4'h0});
    issue(sub_carry_op, 4'he, 1'b1, 32'h5, 32'h3, 32'h0);
    chk({result, flags}, {32'h1, 4'h2});
    issue(reverse_sub_op, 4'he, 1'b1, 32'h1, 32'h0, 32'h0);
    chk({result, flags}, {32'hffffffff, 4'h8});
    issue(compare_neg_op, 4'he, 1'b1, 32'h80000000, 32'h80000000, 32'h0);
    chk({wr_rd, flags}, {1'b0, 4'h7});
    issue(or_not_op, 4'he, 1'b1, 32'h1, 32'hffffffff, 32'h0);
    chk({result, flags}, {32'h1, 4'h3});
    issue(move_not_op, 4'he, 1'b1, 32'h0, 32'h0, 32'h0);
    chk({result, flags}, {32'hffffffff, 4'hb});
    issue(test_equal_op, 4'he, 1'b0, 32'h5, 32'h5, 32'h0);
    chk({wr_rd, flags}, {1'b0, 4'h7});
    issue(shift_arith_op, 4'he, 1'b1, 32'h80000001, 32'h1, 32'h0);
    chk({result, flags}, {32'hc0000000, 4'hb});
    issue(rotate_extend_op, 4'he, 1'b1, 32'h2, 32'h0, 32'h0);
    chk({result, flags}, {32'h80000001, 4'h9});
    issue(rotate_op, 4'he, 1'b1, 32'h1, 32'h1, 32'h0);
    chk({result, flags}, {32'h80000000, 4'hb});
    sat_asr = 1'b1;
    sat_shift = 5'h04;
    issue(signed_saturate_op, 4'he, 1'b0, 32'hfffff000, 32'h0, 32'h0);
    chk({result, sat_q}, {32'hffffff80, 1'b1});
  endtask

  // watchdog far beyond the expected run length
  initial begin
    #(8 * 2000);
    mismatches++;
    end_sim();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk({flags, sat_q, irq_mask, res_valid}, 64'h0);
    t_arith();
    t_cond();
    t_logic();
    t_mul();
    t_bits();
    blk(block_store_descending_op, 32'h100, 16'h0003, 1'b1,
        32'hf8, 5'h02, 32'hf8, 1'b0);
    blk(block_store_ascending_op, 32'h10, 16'h0001, 1'b1,
        32'h10, 5'h01, 32'h14, 1'b0);
    blk(block_load_descending_op, 32'h200, 16'h00ff, 1'b1,
        32'h1e0, 5'h08, 32'h1e0, 1'b1);
    blk(block_load_ascending_op, 32'h40, 16'h8001, 1'b0,
        32'h40, 5'h02, 32'h48, 1'b1);
    t_ctrl();
    t_forms();
    end_sim();
  end
endmodule
